// [rtl/ccs_pkg.sv]
// Constants, register map and state types of the clock source unit.
// Assumes a single 100 MHz core clock and an 8-bit register port.
//
// What this block does
// - Bypass external, loop stays locked for debug
// - Bypass external low power: loop off
// - Stop halts system, debug link and fixed clock outputs
// - Internal ref out runs in stop if enabled
// - External ref out runs in stop if enabled
// - Ref select change restarts loop locking
// - Switch after new clock cycles, else hold
// - Bus divider takes effect immediately
// - Internal ref out when its enable set
// - Larger trim gives longer internal period
// - Trim reaches system output only in internal bypass
// - Trim values survive every reset
// - External ref out; loop ignores it internally
// - Divided loop reference as fixed clock
// - Fixed valid always high in locked modes
// - Bypass fixed valid follows divider table
// - Bus divider codes 1, 2, 4, 8
// - Reset: locked internal, select 00, ref 1
// - Select 01 bypasses to internal reference
package ccs_pkg;
    // Register indices
    localparam logic [1:0] CCS_CTRL1_IDX = 2'h0;
    localparam logic [1:0] CCS_CTRL2_IDX = 2'h1;
    localparam logic [1:0] CCS_TRIM_IDX = 2'h2;
    localparam logic [1:0] CCS_STAT_IDX = 2'h3;
    // Control 1 field positions
    localparam int CCS_CS_LSB = 6;
    localparam int CCS_REF_DIVIDER_LSB = 3;
    localparam int CCS_IRS_BIT = 2;
    localparam int CCS_IREN_BIT = 1;
    localparam int CCS_IRSTEN_BIT = 0;
    // Control 2 field positions
    localparam int CCS_BUS_DIVIDER_LSB = 6;
    localparam int CCS_LP_BIT = 3;
    localparam int CCS_EREN_BIT = 1;
    localparam int CCS_ERSTEN_BIT = 0;
    // Status field positions
    localparam int CCS_LOCK_BIT = 5;
    localparam int CCS_FFV_BIT = 4;
    localparam int CCS_ST_LSB = 2;
    localparam int CCS_FINE_TRIM_BIT = 0;
    // Values after reset, and the power-up trim value
    localparam logic [1:0] CCS_CS_RST = 2'h0;
    localparam logic [2:0] CCS_REF_DIVIDER_RST = 3'h0;
    localparam logic CCS_IRS_RST = 1'b1;
    localparam logic [1:0] CCS_BUS_DIVIDER_RST = 2'h1;
    localparam logic [7:0] CCS_TRIM_INIT = 8'h80;
    // Clock select codes
    localparam logic [1:0] CCS_SEL_LOOP = 2'h0;
    localparam logic [1:0] CCS_SEL_INT = 2'h1;
    localparam logic [1:0] CCS_SEL_EXT = 2'h2;
    localparam logic [1:0] CCS_SEL_RSVD = 2'h3;
    // Timing
    localparam int CCS_CLK_PERIOD_NS = 10;
    localparam int CCS_EXT_TIMEOUT_NS = 40000;
    localparam logic [11:0] CCS_EXT_TIMEOUT_CYC = 12'(CCS_EXT_TIMEOUT_NS / CCS_CLK_PERIOD_NS);
    localparam logic [15:0] CCS_IRC_HALF_BASE = 16'h0040;
    localparam logic [2:0] CCS_LOCK_REF_CYC = 3'h4;
    localparam logic [2:0] CCS_SWITCH_CYC = 3'h3;
    // Loop states, Gray along off, acquire, locked
    typedef enum logic [1:0] {
        CCS_LOOP_OFF = 2'b00,
        CCS_LOOP_ACQ = 2'b01,
        CCS_LOOP_LOCK = 2'b11
    } ccs_loop_t;
endpackage

// [rtl/ccs_pow2_div.sv]
// Power-of-two divider for a slow clock level sampled on core_clk.
// Assumes the input level changes at most once per core_clk cycle.
`timescale 1ns/10ps
`default_nettype none
module ccs_pow2_div #(
    parameter int SEL_W = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clkIn,
    input wire logic [SEL_W-1:0] sel,
    output logic clkOut
);
    localparam int CNT_W = (1 << SEL_W) - 1;
    logic inPrev_reg;
    logic [CNT_W-1:0] cnt_reg;
    wire logic rise;
    wire logic [CNT_W:0] taps;

    // Rising edges advance a ripple of halving stages
    assign rise = clkIn & ~inPrev_reg;
    assign taps = {cnt_reg, clkIn};

    always_ff @(posedge clk) begin
        if (srst) begin
            inPrev_reg <= 1'b0;
            cnt_reg <= '0;
            clkOut <= 1'b0;
        end else begin
            inPrev_reg <= clkIn;
            if (rise) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            clkOut <= taps[sel]; // Tap 0 is the undivided level
        end
    end
endmodule // ccs_pow2_div
`default_nettype wire

// [rtl/ccs_clock_source.sv]
// Clock source unit: internal reference, external reference, loop,
// output switch, bus divider, reference outputs and fixed clock.
// Assumes stopReq and debugActive come from core_clk logic; extRefIn is a pin.
`timescale 1ns/10ps
`default_nettype none
module ccs_clock_source
    import ccs_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic extRefIn,
    input wire logic debugActive,
    input wire logic stopReq,
    output logic systemClockOut,
    output logic debugLinkClock,
    output logic internalRefClockOut,
    output logic externalRefClockOut,
    output logic fixedFreqClock,
    output logic fixedFreqValid
);
    ////////////////////////////////////////////////////////////////////////
    // Registers and declarations
    logic [1:0] clockSelect_reg;
    logic [2:0] refDivider_reg;
    logic internalRefSelect_reg;
    logic intRefOutEnable_reg;
    logic intRefStopEnable_reg;
    logic [1:0] busDivider_reg;
    logic lowPower_reg;
    logic extRefOutEnable_reg;
    logic extRefStopEnable_reg;
    logic [7:0] coarseTrim_reg = CCS_TRIM_INIT;
    logic fineTrim_reg = 1'b0;
    logic extMeta_reg;
    logic extSync_reg;
    logic extPrev_reg;
    logic [11:0] extIdle_reg;
    logic [15:0] ircCnt_reg;
    logic ircClk_reg;
    ccs_loop_t loopState_reg;
    ccs_loop_t loopState_next;
    logic [2:0] lockCnt_reg;
    logic irsPrev_reg;
    logic loopClk_reg;
    logic ffPrev_reg;
    logic [1:0] activeSel_reg;
    logic newPrev_reg;
    logic [2:0] swCnt_reg;
    wire logic wrCtrl1;
    wire logic wrCtrl2;
    wire logic wrTrim;
    wire logic wrStat;
    wire logic extRise;
    wire logic extAvail;
    wire logic [15:0] ircHalf;
    wire logic ircTick;
    wire logic refLevel;
    wire logic refDivided;
    wire logic ffRise;
    wire logic loopEnable;
    wire logic loopLocked;
    wire logic irsChanged;
    wire logic newLevel;
    wire logic newAvail;
    wire logic newRise;
    wire logic switchPending;
    wire logic activeLevel;
    wire logic busClk;
    wire logic ffValidNext;
    wire logic [7:0] rdMux;

    ////////////////////////////////////////////////////////////////////////
    // Register port decode
    assign wrCtrl1 = regWrEn && regAddr == CCS_CTRL1_IDX;
    assign wrCtrl2 = regWrEn && regAddr == CCS_CTRL2_IDX;
    assign wrTrim = regWrEn && regAddr == CCS_TRIM_IDX;
    assign wrStat = regWrEn && regAddr == CCS_STAT_IDX;

    // Control registers, reset into locked internal mode
    always_ff @(posedge core_clk) begin
        if (srst) begin
            clockSelect_reg <= CCS_CS_RST;
            refDivider_reg <= CCS_REF_DIVIDER_RST;
            internalRefSelect_reg <= CCS_IRS_RST;
            intRefOutEnable_reg <= 1'b0;
            intRefStopEnable_reg <= 1'b0;
            busDivider_reg <= CCS_BUS_DIVIDER_RST;
            lowPower_reg <= 1'b0;
            extRefOutEnable_reg <= 1'b0;
            extRefStopEnable_reg <= 1'b0;
        end else begin
            if (wrCtrl1) begin
                if (regWrData[CCS_CS_LSB+:2] != CCS_SEL_RSVD) begin
                    clockSelect_reg <= regWrData[CCS_CS_LSB+:2];
                end
                refDivider_reg <= regWrData[CCS_REF_DIVIDER_LSB+:3];
                internalRefSelect_reg <= regWrData[CCS_IRS_BIT];
                intRefOutEnable_reg <= regWrData[CCS_IREN_BIT];
                intRefStopEnable_reg <= regWrData[CCS_IRSTEN_BIT];
            end
            if (wrCtrl2) begin
                busDivider_reg <= regWrData[CCS_BUS_DIVIDER_LSB+:2];
                lowPower_reg <= regWrData[CCS_LP_BIT];
                extRefOutEnable_reg <= regWrData[CCS_EREN_BIT];
                extRefStopEnable_reg <= regWrData[CCS_ERSTEN_BIT];
            end
        end
    end

    // Trim settings ignore reset entirely
    always_ff @(posedge core_clk) begin
        if (wrTrim) begin
            coarseTrim_reg <= regWrData;
        end
        if (wrStat) begin
            fineTrim_reg <= regWrData[CCS_FINE_TRIM_BIT];
        end
    end

    // Read data, one cycle after the strobe
    assign rdMux = (regAddr == CCS_CTRL1_IDX) ?
        {clockSelect_reg, refDivider_reg, internalRefSelect_reg,
         intRefOutEnable_reg, intRefStopEnable_reg} :
        (regAddr == CCS_CTRL2_IDX) ?
        {busDivider_reg, 2'h0, lowPower_reg, 1'b0,
         extRefOutEnable_reg, extRefStopEnable_reg} :
        (regAddr == CCS_TRIM_IDX) ? coarseTrim_reg :
        {2'h0, loopLocked, fixedFreqValid, activeSel_reg, 1'b0, fineTrim_reg};

    always_ff @(posedge core_clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRdEn ? rdMux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External reference: synchroniser and activity watch
    assign extRise = extSync_reg & ~extPrev_reg;
    assign extAvail = extIdle_reg < CCS_EXT_TIMEOUT_CYC;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            extMeta_reg <= 1'b0;
            extSync_reg <= 1'b0;
            extPrev_reg <= 1'b0;
            extIdle_reg <= CCS_EXT_TIMEOUT_CYC;
        end else begin
            extMeta_reg <= extRefIn;
            extSync_reg <= extMeta_reg;
            extPrev_reg <= extSync_reg;
            if (extRise) begin
                extIdle_reg <= 12'h000;
            end else if (extAvail) begin
                extIdle_reg <= extIdle_reg + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal reference oscillator, half period grows with trim
    assign ircHalf = CCS_IRC_HALF_BASE + {7'h00, coarseTrim_reg, fineTrim_reg};
    assign ircTick = ircCnt_reg >= ircHalf - 16'h0001;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ircCnt_reg <= 16'h0000;
            ircClk_reg <= 1'b0;
        end else begin
            ircCnt_reg <= ircTick ? 16'h0000 : ircCnt_reg + 16'h0001;
            ircClk_reg <= ircClk_reg ^ ircTick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop reference and its divided form, the fixed clock
    assign refLevel = internalRefSelect_reg ? ircClk_reg : extSync_reg;

    ccs_pow2_div #(.SEL_W(3)) u_refDiv (
        .clk(core_clk),
        .srst(srst),
        .clkIn(refLevel),
        .sel(refDivider_reg),
        .clkOut(refDivided)
    );

    assign ffRise = refDivided & ~ffPrev_reg;

    ////////////////////////////////////////////////////////////////////////
    // Loop enable and lock sequencing
    assign loopEnable = !stopReq && (clockSelect_reg == CCS_SEL_LOOP ||
        debugActive || !lowPower_reg);
    assign irsChanged = internalRefSelect_reg != irsPrev_reg;
    assign loopLocked = loopState_reg == CCS_LOOP_LOCK;

    always_comb begin
        loopState_next = loopState_reg;
        case (loopState_reg)
            CCS_LOOP_OFF: begin
                if (loopEnable) begin
                    loopState_next = CCS_LOOP_ACQ;
                end
            end
            CCS_LOOP_ACQ: begin
                if (!loopEnable) begin
                    loopState_next = CCS_LOOP_OFF;
                end else if (!irsChanged && ffRise && lockCnt_reg == CCS_LOCK_REF_CYC - 3'h1) begin
                    loopState_next = CCS_LOOP_LOCK;
                end
            end
            CCS_LOOP_LOCK: begin
                if (!loopEnable) begin
                    loopState_next = CCS_LOOP_OFF;
                end else if (irsChanged) begin
                    loopState_next = CCS_LOOP_ACQ;
                end
            end
            default: begin
                loopState_next = CCS_LOOP_OFF;
            end
        endcase
    end

    // Lock counter counts whole divided reference cycles
    always_ff @(posedge core_clk) begin
        if (srst) begin
            loopState_reg <= CCS_LOOP_OFF;
            lockCnt_reg <= 3'h0;
            irsPrev_reg <= CCS_IRS_RST;
            ffPrev_reg <= 1'b0;
            loopClk_reg <= 1'b0;
        end else begin
            loopState_reg <= loopState_next;
            irsPrev_reg <= internalRefSelect_reg;
            ffPrev_reg <= refDivided;
            if (loopState_reg != CCS_LOOP_ACQ || irsChanged) begin
                lockCnt_reg <= 3'h0;
            end else if (ffRise) begin
                lockCnt_reg <= lockCnt_reg + 3'h1;
            end
            loopClk_reg <= (loopState_reg != CCS_LOOP_OFF) ? ~loopClk_reg : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output switch: wait whole cycles of the new source
    assign newLevel = (clockSelect_reg == CCS_SEL_LOOP) ? loopClk_reg :
        (clockSelect_reg == CCS_SEL_INT) ? ircClk_reg : extSync_reg;
    assign newAvail = (clockSelect_reg == CCS_SEL_LOOP) ? loopLocked :
        (clockSelect_reg == CCS_SEL_INT) ? 1'b1 : extAvail;
    assign newRise = newLevel & ~newPrev_reg;
    assign switchPending = clockSelect_reg != activeSel_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            activeSel_reg <= CCS_CS_RST;
            newPrev_reg <= 1'b0;
            swCnt_reg <= 3'h0;
        end else begin
            newPrev_reg <= newLevel | wrCtrl1; // Masks the false rise of a source change
            if (!switchPending || !newAvail || wrCtrl1) begin
                swCnt_reg <= 3'h0;
            end else if (newRise) begin
                if (swCnt_reg == CCS_SWITCH_CYC - 3'h1) begin
                    activeSel_reg <= clockSelect_reg;
                    swCnt_reg <= 3'h0;
                end else begin
                    swCnt_reg <= swCnt_reg + 3'h1;
                end
            end
        end
    end

    // Selected source, only internal bypass carries the trim
    assign activeLevel = (activeSel_reg == CCS_SEL_LOOP) ? loopClk_reg :
        (activeSel_reg == CCS_SEL_INT) ? ircClk_reg : extSync_reg;

    ccs_pow2_div #(.SEL_W(2)) u_busDiv (
        .clk(core_clk),
        .srst(srst),
        .clkIn(activeLevel),
        .sel(busDivider_reg),
        .clkOut(busClk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Fixed clock qualifier
    assign ffValidNext = (activeSel_reg == CCS_SEL_LOOP) ? 1'b1 :
        ({1'b0, refDivider_reg} >= {2'h0, busDivider_reg} + 4'h2);

    // Output clocks, gated in stop; reference outputs run on in stop if their stop enable is set
    always_ff @(posedge core_clk) begin
        if (srst) begin
            systemClockOut <= 1'b0;
            debugLinkClock <= 1'b0;
            internalRefClockOut <= 1'b0;
            externalRefClockOut <= 1'b0;
            fixedFreqClock <= 1'b0;
            fixedFreqValid <= 1'b1;
        end else begin
            systemClockOut <= !stopReq && busClk;
            debugLinkClock <= !stopReq && loopLocked && loopClk_reg;
            internalRefClockOut <= intRefOutEnable_reg && ircClk_reg &&
                (!stopReq || intRefStopEnable_reg);
            externalRefClockOut <= extRefOutEnable_reg && extSync_reg &&
                (!stopReq || extRefStopEnable_reg);
            fixedFreqClock <= !stopReq && refDivided;
            fixedFreqValid <= ffValidNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking ccs_cb @(posedge core_clk); endclocking
    default disable iff (srst);

    stop_sysclk_a: assert property (stopReq |=> !systemClockOut && !debugLinkClock)
        else $error("system clock ran during stop");
    irc_stop_a: assert property (stopReq && !(intRefOutEnable_reg && intRefStopEnable_reg)
        |=> !internalRefClockOut)
        else $error("internal reference out ran in stop");
    erc_stop_a: assert property (stopReq && !(extRefOutEnable_reg && extRefStopEnable_reg)
        |=> !externalRefClockOut)
        else $error("external reference out ran in stop");
    reserved_sel_a: assert property (wrCtrl1 && regWrData[CCS_CS_LSB+:2] == CCS_SEL_RSVD
        |=> $stable(clockSelect_reg))
        else $error("reserved select code was taken");
    ffv_locked_a: assert property (activeSel_reg == CCS_SEL_LOOP |=> fixedFreqValid)
        else $error("qualifier low in locked mode");
    ffv_table_a: assert property (activeSel_reg != CCS_SEL_LOOP && busDivider_reg == 2'h3 &&
        refDivider_reg < 3'h5 |=> !fixedFreqValid)
        else $error("qualifier high outside table");
    loop_lowpow_a: assert property (clockSelect_reg == CCS_SEL_EXT && lowPower_reg &&
        !debugActive |=> loopState_reg == CCS_LOOP_OFF)
        else $error("loop running in low power bypass");
    switch_avail_a: assert property (activeSel_reg != $past(activeSel_reg)
        |-> $past(newAvail) && $past(newRise))
        else $error("switched to an unavailable clock");
    irs_relock_a: assert property (irsChanged && loopLocked && loopEnable
        |=> loopState_reg == CCS_LOOP_ACQ [*2])
        else $error("loop kept lock across reference change");
    sys_div1_a: assert property (!stopReq && busDivider_reg == 2'h0 && $stable(busDivider_reg)
        ##1 !stopReq |=> systemClockOut == $past(activeLevel, 2))
        else $error("divide by one path wrong");

    sw_ext_c: cover property (activeSel_reg == CCS_SEL_LOOP ##1 activeSel_reg == CCS_SEL_EXT);
    lock_c: cover property (loopState_reg == CCS_LOOP_ACQ ##1 loopLocked);
    irc_stop_c: cover property (stopReq && internalRefClockOut);
    ffv_bypass_c: cover property (activeSel_reg == CCS_SEL_INT && fixedFreqValid);
endmodule // ccs_clock_source
`default_nettype wire

// [verification/ccs_ext_osc_model.sv]
// External reference oscillator that drives the extRefIn pin.
// Assumes the bench gates it; the pin rests low while it is stopped.
`timescale 1ns/10ps
`default_nettype none
module ccs_ext_osc_model (
    input wire logic runEn,
    input wire logic slow,
    output logic extRefIn
);
    // Free oscillator, phase unrelated to core_clk, fast or slow
    initial begin
        extRefIn = 1'b0;
        forever begin
            #(slow ? 211 : 73);
            extRefIn = runEn ? ~extRefIn : 1'b0;
        end
    end
endmodule // ccs_ext_osc_model
`default_nettype wire

// [verification/fll_clock_source_modes_tb.sv]
// Self-checking bench for the clock source unit.
// Assumes the oscillator model at extRefIn and a 100 MHz core_clk.
`timescale 1ns/10ps
`default_nettype none
module fll_clock_source_modes_tb;
    import ccs_pkg::*;
    logic core_clk, srst, regWrEn, regRdEn, debugActive, stopReq, extRun, extSlow;
    logic [1:0] regAddr;
    logic [7:0] regWrData, regRdData, d, t;
    logic f;
    logic extRefIn, systemClockOut, debugLinkClock, internalRefClockOut;
    logic externalRefClockOut, fixedFreqClock, fixedFreqValid;
    int nErrors = 0;
    int samplesChecked = 0;
    int n, p, pa, pb, pc;
    integer seed = 41921;

    ccs_clock_source ccs_clock_source_i (.core_clk(core_clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .extRefIn(extRefIn), .debugActive(debugActive),
        .stopReq(stopReq), .systemClockOut(systemClockOut), .debugLinkClock(debugLinkClock),
        .internalRefClockOut(internalRefClockOut),
        .externalRefClockOut(externalRefClockOut), .fixedFreqClock(fixedFreqClock),
        .fixedFreqValid(fixedFreqValid));
    ccs_ext_osc_model ccs_ext_osc_model_i (.runEn(extRun), .slow(extSlow), .extRefIn(extRefIn));

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge core_clk);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= v;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1;
        v = regRdData;
    endtask

    // Picks one clock output by number
    function automatic logic sig(input int k);
        case (k)
            0: return systemClockOut;
            1: return debugLinkClock;
            2: return internalRefClockOut;
            3: return externalRefClockOut;
            default: return fixedFreqClock;
        endcase
    endfunction

    // Bypass qualifier expected from divider settings
    function automatic logic ffvExp(input logic [1:0] b, input logic [2:0] r);
        case (b)
            2'h0: return r >= 3'h2;
            2'h1: return r >= 3'h3;
            2'h2: return r >= 3'h4;
            default: return r >= 3'h5;
        endcase
    endfunction

    // Counts rising edges; period between 2nd and 3rd skips a settling cycle
    task automatic edges(input int k, input int win, output int cnt, output int per);
        logic prev;
        int t1;
        int t2;
        cnt = 0;
        t1 = 0;
        t2 = 0;
        prev = sig(k);
        for (int c = 0; c < win; c++) begin
            @(posedge core_clk);
            #1;
            if (sig(k) && !prev) begin
                cnt++;
                if (cnt == 2) t1 = c;
                if (cnt == 3) t2 = c;
            end
            prev = sig(k);
        end
        per = t2 - t1;
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge core_clk);
        nErrors++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        srst = 1'b1;
        regAddr = 2'h0;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        debugActive = 1'b0;
        stopReq = 1'b0;
        extRun = 1'b1;
        extSlow = 1'b0;
        wt(8);
        srst <= 1'b0;
        rd(CCS_CTRL1_IDX, d); chk(d, 8'h04);
        rd(CCS_CTRL2_IDX, d); chk(d, 8'h40);
        // Locked mode with a bypass-failing divider pair
        wr(CCS_CTRL2_IDX, 8'hc0);
        wt(10);
        chk(fixedFreqValid, 1'b1);
        edges(4, 2000, n, p); chk(n > 0, 1'b1);
        // Reserved select keeps the loop, other fields land
        wr(CCS_CTRL1_IDX, 8'hfc);
        rd(CCS_CTRL1_IDX, d); chk(d, 8'h3c);
        rd(CCS_STAT_IDX, d); chk(d[3:2], CCS_SEL_LOOP);
        // Trim survives a mid-run reset
        t = 8'($random(seed));
        f = 1'($random(seed));
        wr(CCS_TRIM_IDX, t);
        wr(CCS_STAT_IDX, {7'h00, f});
        @(posedge core_clk);
        srst <= 1'b1;
        wt(3);
        srst <= 1'b0;
        rd(CCS_TRIM_IDX, d); chk(d, t);
        rd(CCS_STAT_IDX, d); chk(d[0], f);
        rd(CCS_CTRL1_IDX, d); chk(d, 8'h04);
        // Fastest internal reference, then bypass to it
        wr(CCS_TRIM_IDX, 8'h00);
        wr(CCS_STAT_IDX, 8'h00);
        wr(CCS_CTRL1_IDX, 8'h46);
        wr(CCS_CTRL2_IDX, 8'h00);
        wt(600);
        rd(CCS_STAT_IDX, d); chk(d[3:2], CCS_SEL_INT);
        // Trim steps on the internal reference period
        t = 8'($random(seed)) & 8'h3f;
        wr(CCS_TRIM_IDX, t); edges(2, 1500, n, pa);
        wr(CCS_TRIM_IDX, t + 8'h10); edges(2, 1500, n, pb);
        chk(16'(pb - pa), 16'h0040);
        wr(CCS_STAT_IDX, 8'h01); edges(2, 1500, n, pc);
        chk(16'(pc - pb), 16'h0002);
        wr(CCS_TRIM_IDX, 8'h00);
        wr(CCS_STAT_IDX, 8'h00);
        // Bus divider codes against the reference period
        edges(2, 1500, n, pa);
        for (int b = 0; b < 4; b++) begin
            wr(CCS_CTRL2_IDX, 8'(b << 6));
            edges(0, 4000, n, pb); chk(16'(pb), 16'(pa << b));
        end
        // Qualifier over every divider pair in bypass
        for (int b = 0; b < 4; b++) begin
            for (int r = 0; r < 8; r++) begin
                wr(CCS_CTRL1_IDX, {2'b01, 3'(r), 3'b110});
                wr(CCS_CTRL2_IDX, {2'(b), 6'h00});
                wt(4);
                chk(fixedFreqValid, ffvExp(2'(b), 3'(r)));
            end
        end
        // Reference outputs follow their enables
        for (int e = 0; e < 4; e++) begin
            wr(CCS_CTRL1_IDX, {5'b01000, 1'b1, e[0], 1'b0});
            wr(CCS_CTRL2_IDX, {6'h00, e[1], 1'b0});
            edges(2, 400, n, p); chk(n > 0, e[0]);
            edges(3, 400, n, p); chk(n > 0, e[1]);
        end
        // External select with the oscillator dead holds the old clock
        extRun <= 1'b0;
        wr(CCS_CTRL2_IDX, 8'h0a);
        wr(CCS_CTRL1_IDX, 8'h82);
        wt(4300);
        rd(CCS_STAT_IDX, d); chk(d[3:2], CCS_SEL_INT);
        extRun <= 1'b1;
        extSlow <= 1'($random(seed));
        wr(CCS_CTRL1_IDX, 8'h82);
        wt(300);
        rd(CCS_STAT_IDX, d); chk(d[3:2], CCS_SEL_EXT);
        // Low power bypass: loop off unless debug is active
        edges(1, 600, n, p); chk(16'(n), 16'h0000);
        edges(0, 600, n, p); chk(n > 0, 1'b1);
        @(posedge core_clk);
        debugActive <= 1'b1;
        wt(600);
        edges(1, 600, n, p); chk(n > 0, 1'b1);
        @(posedge core_clk);
        debugActive <= 1'b0;
        // Stop keeps only the reference outputs enabled for it
        for (int k = 0; k < 2; k++) begin
            wr(CCS_CTRL1_IDX, 8'h82 | 8'(k));
            wr(CCS_CTRL2_IDX, 8'h02 | 8'(1 - k));
            @(posedge core_clk);
            stopReq <= 1'b1;
            wt(3);
            for (int s = 0; s < 5; s++) begin
                edges(s, 500, n, p);
                chk(n > 0, (s == 2 && k == 1) || (s == 3 && k == 0));
            end
            @(posedge core_clk);
            stopReq <= 1'b0;
        end
        // Leave bypass for locked internal, then relock on the external reference
        wr(CCS_CTRL2_IDX, 8'h00);
        wr(CCS_CTRL1_IDX, 8'h04);
        wt(800);
        rd(CCS_STAT_IDX, d); chk(d, 8'h30);
        wr(CCS_CTRL1_IDX, 8'h00);
        rd(CCS_STAT_IDX, d); chk(d[5], 1'b0);
        wt(400);
        rd(CCS_STAT_IDX, d); chk(d[5], 1'b1);
        wrap_up();
    end
endmodule // fll_clock_source_modes_tb
`default_nettype wire
